// ---- hw/hf_postscaler.sv ----
// Postscaler of the high oscillator, giving one tap per frequency code
`timescale 1ns/1ps
`default_nettype none
module hf_postscaler
  import osc_clock_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic hfWave,
  input wire logic lfWave,
  output logic [TAP_W-1:0] taps
);
  logic hfPrev_r;
  logic [PSC_W-1:0] div_r;
  logic hfRise;
  logic [PSC_W-1:0] divRev;

  assign hfRise = hfWave && !hfPrev_r;

  // Code 1 takes the deepest stage, code 6 the first
  genvar i;
  generate
    for (i = 0; i < PSC_W; i++)
    begin : g_rev
      assign divRev[i] = div_r[PSC_W-1-i];
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      hfPrev_r <= 1'b0;
      div_r <= '0;
    end
    else
    begin
      hfPrev_r <= hfWave;
      if (hfRise)
        div_r <= div_r + 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      taps <= '0;
    else
      taps <= {hfWave, divRev, lfWave}; // R17
  end

  property p_div_counts;
    @(posedge clk_sys) disable iff (!reset_n)
    hfRise |=> div_r == $past(div_r) + 1'b1;
  endproperty
  a_div_counts: assert property (p_div_counts) // R02
    else $error("postscaler missed a high oscillator edge");
endmodule
`default_nettype wire

// ---- hw/internal_osc_clock_select.sv ----
// Internal oscillator enables, frequency select, glitch-free switch and pin modes
//
// Behaviour
// R01 - Two internal oscillators: trimmed 8 MHz high source and rough 31 kHz low source.
// R02 - Three-bit frequency select picks one of eight frequencies; reset selects 4 MHz.
// R03 - High oscillator runs for nonzero select with internal source or two-speed start-up.
// R04 - Low oscillator runs for select 000 likewise, or for power-up, watchdog, fail-safe.
// R05 - Low oscillator also clocks power-up timer, watchdog and fail-safe monitor.
// R06 - Status holds high-oscillator-stable and low-oscillator-stable bits.
// R07 - Switching to a shut-down oscillator waits a 10 us start-up delay first.
// R08 - Switch waits for current clock falling edge, then holds clock out low.
// R09 - On the new clock's rising edge connect it and update stable bits.
// R10 - Switching among 8 MHz down to 125 kHz needs no start-up delay.
// R11 - Clock-out mode: pin A is general I/O, pin B outputs clock divided by 4.
// R12 - I/O mode: both pins are general I/O, no clock is driven.
// R13 - Oscillator mode comes from configuration select bits fixed at programming.
// R14 - Clock source select chooses external or internal system clock.
// R15 - Software trim value adjusts high oscillator by roughly twelve percent either way.
// R16 - Factory trim word at 2008h, written only in programming, survives bulk erase.
// R17 - Codes 001 to 111 ascend 125 kHz to 8 MHz; 000 is 31 kHz.
`timescale 1ns/1ps
`default_nettype none
module internal_osc_clock_select
  import osc_clock_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic freqSelectWr,
  input wire logic [FREQ_W-1:0] freqSelectIn,
  input wire logic clockSourceSelect,
  input wire logic twoSpeedStartupEn,
  input wire logic powerupTimerEn,
  input wire logic watchdogTimerEn,
  input wire logic failsafeMonitorEn,
  input wire logic oscTrimWr,
  input wire logic [TRIM_W-1:0] oscTrimIn,
  input wire logic [CFG_W-1:0] oscConfigSelect,
  input wire logic extClkIn,
  input wire logic gpioAOut,
  input wire logic gpioAOe,
  input wire logic gpioBOut,
  input wire logic gpioBOe,
  input wire logic progMode,
  input wire logic progWr,
  input wire logic [PROG_ADDR_W-1:0] progAddr,
  input wire logic [PROG_ADDR_W-1:0] progWrData,
  input wire logic bulkErase,
  output logic [FREQ_W-1:0] freqSelect,
  output logic [TRIM_W-1:0] oscTrim,
  output logic highOscStable,
  output logic lowOscStable,
  output logic highOscRun,
  output logic lowOscRun,
  output logic switchBusy,
  output logic sysClock,
  output logic lowFreqClock,
  output logic dividedClockOut,
  output logic oscPinAOut,
  output logic oscPinAOe,
  output logic oscPinBOut,
  output logic oscPinBOe,
  output logic [PROG_ADDR_W-1:0] factoryTrimWord,
  output logic [PROG_ADDR_W-1:0] progRdData
);
  switch_state_t state_r;
  switch_state_t state_nxt;
  logic activeCss_r;
  logic [FREQ_W-1:0] activeFreq_r;
  logic targetCss_r;
  logic [FREQ_W-1:0] targetFreq_r;
  logic [CFG_W-1:0] cfgMode_r;
  logic cfgTaken_r;
  logic curPrev_r;
  logic newPrev_r;
  logic [DIVIDED_CLOCK_OUT_CNT_W-1:0] clkoutCnt_r;
  logic hfWave;
  logic lfWave;
  logic hfReady;
  logic lfReady;
  logic [TAP_W-1:0] taps;
  logic [TRIM_W-1:0] trimSum;
  logic signed [TRIM_W:0] trimWide;
  logic curLevel;
  logic newLevel;
  logic curFall;
  logic newRise;
  logic curRise;
  logic reqChange;
  logic newReady;
  logic hold;
  logic clkoutMode;
  logic ioMode;
  logic hfWanted;
  logic lfWanted;

  // ---------------------------------------------------------------
  // Software controls
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      freqSelect <= FREQ_RESET; // R02
    else if (freqSelectWr)
      freqSelect <= freqSelectIn; // R02
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      oscTrim <= TRIM_RESET;
    else if (oscTrimWr)
      oscTrim <= oscTrimIn; // R15
  end

  // Factory and user trim add; clamping avoids a wrap to the far end of range
  always_comb
  begin
    trimWide = $signed({factoryTrimWord[TRIM_W-1], factoryTrimWord[TRIM_W-1:0]})
      + $signed({oscTrim[TRIM_W-1], oscTrim});
    if (trimWide > TRIM_MAX)
      trimSum = TRIM_MAX[TRIM_W-1:0]; // R15
    else if (trimWide < TRIM_MIN)
      trimSum = TRIM_MIN[TRIM_W-1:0];
    else
      trimSum = trimWide[TRIM_W-1:0];
  end

  // ---------------------------------------------------------------
  // Configuration space and factory trim word
  // ---------------------------------------------------------------
  // Bulk erase leaves this word alone; no other location is stored here
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      factoryTrimWord <= FACTORY_TRIM_RESET;
    else if (progMode && progWr && !bulkErase && progAddr == FACTORY_TRIM_ADDR)
      factoryTrimWord <= progWrData; // R16
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      progRdData <= '0;
    else if (progMode && progAddr == FACTORY_TRIM_ADDR)
      progRdData <= factoryTrimWord; // R16
    else
      progRdData <= '0;
  end

  // Mode bits are a strap: caught once, on the first edge after release
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfgMode_r <= CFG_RESET;
      cfgTaken_r <= 1'b0;
    end
    else if (!cfgTaken_r)
    begin
      cfgMode_r <= oscConfigSelect; // R13
      cfgTaken_r <= 1'b1;
    end
  end

  assign clkoutMode = cfgTaken_r && cfgMode_r == CFG_INTOSC_DIVIDED_CLOCK_OUT;
  assign ioMode = cfgTaken_r && cfgMode_r == CFG_INTOSC_IO;

  // ---------------------------------------------------------------
  // Oscillator enables
  // ---------------------------------------------------------------
  assign hfWanted = usesHighOsc(clockSourceSelect || twoSpeedStartupEn, freqSelect); // R03
  assign lfWanted = usesLowOsc(clockSourceSelect || twoSpeedStartupEn, freqSelect)
    || powerupTimerEn || watchdogTimerEn || failsafeMonitorEn; // R04

  // The old source keeps running until the switch has let go of it
  assign highOscRun = hfWanted || usesHighOsc(activeCss_r, activeFreq_r)
    || (switchBusy && usesHighOsc(targetCss_r, targetFreq_r)); // R03
  assign lowOscRun = lfWanted || usesLowOsc(activeCss_r, activeFreq_r)
    || (switchBusy && usesLowOsc(targetCss_r, targetFreq_r)); // R04

  internal_osc_core #(
    .PHASE_INC(HF_PHASE_INC),
    .TRIM_STEP(HF_TRIM_STEP)
  ) u_high_osc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .enable(highOscRun),
    .trim(trimSum),
    .wave(hfWave),
    .ready(hfReady)
  );

  internal_osc_core #(
    .PHASE_INC(LF_PHASE_INC),
    .TRIM_STEP(NO_TRIM_STEP)
  ) u_low_osc (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .enable(lowOscRun),
    .trim(TRIM_RESET),
    .wave(lfWave),
    .ready(lfReady)
  );

  hf_postscaler u_postscaler (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .hfWave(hfWave),
    .lfWave(lfWave),
    .taps(taps)
  );

  assign lowFreqClock = lfWave; // R05

  // ---------------------------------------------------------------
  // Clock switch sequencer
  // ---------------------------------------------------------------
  assign curLevel = activeCss_r ? tapSelect(taps, activeFreq_r) : extClkIn; // R14
  assign newLevel = targetCss_r ? tapSelect(taps, targetFreq_r) : extClkIn; // R14
  assign curFall = curPrev_r && !curLevel;
  assign curRise = !curPrev_r && curLevel;
  assign newRise = !newPrev_r && newLevel;
  assign reqChange = (clockSourceSelect != activeCss_r) || (freqSelect != activeFreq_r);
  assign newReady = !targetCss_r
    || (usesHighOsc(targetCss_r, targetFreq_r) ? hfReady : lfReady);
  assign switchBusy = state_r != ST_IDLE;
  assign hold = state_r == ST_WAIT_RISE;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      curPrev_r <= 1'b0;
      newPrev_r <= 1'b0;
    end
    else
    begin
      curPrev_r <= curLevel;
      newPrev_r <= newLevel;
    end
  end

  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE:
      begin
        if (reqChange)
        begin
          if (usesHighOsc(clockSourceSelect, freqSelect) ? hfReady
              : (!clockSourceSelect || lfReady))
            state_nxt = ST_WAIT_FALL; // R10
          else
            state_nxt = ST_STARTUP; // R07
        end
      end
      ST_STARTUP:
      begin
        if (newReady)
          state_nxt = ST_WAIT_FALL; // R07
      end
      ST_WAIT_FALL:
      begin
        if (curFall)
          state_nxt = ST_WAIT_RISE; // R08
      end
      ST_WAIT_RISE:
      begin
        if (newRise)
          state_nxt = ST_IDLE; // R09
      end
      default:
        state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Target is frozen for the whole switch; later writes wait for idle
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      targetCss_r <= 1'b1;
      targetFreq_r <= FREQ_RESET;
    end
    else if (state_r == ST_IDLE && reqChange)
    begin
      targetCss_r <= clockSourceSelect;
      targetFreq_r <= freqSelect;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      activeCss_r <= 1'b1;
      activeFreq_r <= FREQ_RESET;
    end
    else if (state_r == ST_WAIT_RISE && newRise)
    begin
      activeCss_r <= targetCss_r; // R09
      activeFreq_r <= targetFreq_r;
    end
  end

  // Stable bits freeze during a switch and are refreshed as it completes
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      highOscStable <= 1'b0;
      lowOscStable <= 1'b0;
    end
    else if (state_r == ST_IDLE || (state_r == ST_WAIT_RISE && newRise))
    begin
      highOscStable <= hfReady; // R06
      lowOscStable <= lfReady; // R06
    end
  end

  // ---------------------------------------------------------------
  // System clock and divided clock output
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      sysClock <= 1'b0;
    else
      sysClock <= hold ? 1'b0 : curLevel; // R08
  end

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      clkoutCnt_r <= '0;
      dividedClockOut <= 1'b0;
    end
    else if (hold)
    begin
      clkoutCnt_r <= '0;
      dividedClockOut <= 1'b0; // R08
    end
    else
    begin
      if (curRise)
        clkoutCnt_r <= clkoutCnt_r + 1'b1;
      dividedClockOut <= clkoutCnt_r[DIVIDED_CLOCK_OUT_CNT_W-1]; // R11
    end
  end

  // ---------------------------------------------------------------
  // Oscillator pins
  // ---------------------------------------------------------------
  assign oscPinAOut = (clkoutMode || ioMode) ? gpioAOut : 1'b0; // R11
  assign oscPinAOe = (clkoutMode || ioMode) && gpioAOe; // R12
  assign oscPinBOut = clkoutMode ? dividedClockOut : (ioMode ? gpioBOut : 1'b0); // R11
  assign oscPinBOe = clkoutMode || (ioMode && gpioBOe); // R12

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  property p_reset_freq;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(reset_n) |-> freqSelect == FREQ_4M;
  endproperty
  a_reset_freq: assert property (p_reset_freq) // R02
    else $error("frequency select not 4 MHz after reset");

  property p_hf_enable;
    @(posedge clk_sys) disable iff (!reset_n)
    (freqSelect != FREQ_31K && (clockSourceSelect || twoSpeedStartupEn)) |-> highOscRun;
  endproperty
  a_hf_enable: assert property (p_hf_enable) // R03
    else $error("high oscillator not running when required");

  property p_lf_enable;
    @(posedge clk_sys) disable iff (!reset_n)
    ((freqSelect == FREQ_31K && (clockSourceSelect || twoSpeedStartupEn))
      || powerupTimerEn || watchdogTimerEn || failsafeMonitorEn) |-> lowOscRun;
  endproperty
  a_lf_enable: assert property (p_lf_enable) // R04
    else $error("low oscillator not running when required");

  property p_startup_wait;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_STARTUP && !newReady) |=> state_r == ST_STARTUP;
  endproperty
  a_startup_wait: assert property (p_startup_wait) // R07
    else $error("switch left start-up before the oscillator was ready");

  property p_wait_fall;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_WAIT_FALL && !curFall) |=> state_r == ST_WAIT_FALL
      && dividedClockOut == $past(clkoutCnt_r[DIVIDED_CLOCK_OUT_CNT_W-1]);
  endproperty
  a_wait_fall: assert property (p_wait_fall) // R08
    else $error("switch did not wait for the current clock falling edge");

  property p_hold_low;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_WAIT_RISE) |=> !dividedClockOut && !sysClock;
  endproperty
  a_hold_low: assert property (p_hold_low) // R08
    else $error("clock out not held low while awaiting new clock");

  property p_connect_new;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_WAIT_RISE && newRise) |=> state_r == ST_IDLE
      && activeFreq_r == $past(targetFreq_r) && highOscStable == $past(hfReady);
  endproperty
  a_connect_new: assert property (p_connect_new) // R09
    else $error("new clock not connected on its rising edge");

  property p_no_delay_hf;
    @(posedge clk_sys) disable iff (!reset_n)
    (state_r == ST_IDLE && reqChange && usesHighOsc(clockSourceSelect, freqSelect) && hfReady)
      |=> state_r == ST_WAIT_FALL;
  endproperty
  a_no_delay_hf: assert property (p_no_delay_hf) // R10
    else $error("start-up delay applied within the postscaler range");

  property p_divided_clock_out_pin;
    @(posedge clk_sys) disable iff (!reset_n)
    clkoutMode |-> oscPinBOe && oscPinBOut == dividedClockOut && oscPinAOe == gpioAOe;
  endproperty
  a_divided_clock_out_pin: assert property (p_divided_clock_out_pin) // R11
    else $error("pin B not carrying the divided clock");

  property p_io_pins;
    @(posedge clk_sys) disable iff (!reset_n)
    ioMode |-> oscPinBOut == gpioBOut && oscPinBOe == gpioBOe && oscPinAOut == gpioAOut;
  endproperty
  a_io_pins: assert property (p_io_pins) // R12
    else $error("pins not released to general I/O");

  property p_trim_protect;
    @(posedge clk_sys) disable iff (!reset_n)
    (!progMode || bulkErase) |=> factoryTrimWord == $past(factoryTrimWord);
  endproperty
  a_trim_protect: assert property (p_trim_protect) // R16
    else $error("factory trim word changed outside programming");
endmodule
`default_nettype wire

// ---- hw/internal_osc_core.sv ----
// Behavioural oscillator: phase accumulator with trim and start-up ready flag
`timescale 1ns/1ps
`default_nettype none
module internal_osc_core
  import osc_clock_pkg::*;
#(
  parameter logic [31:0] PHASE_INC = HF_PHASE_INC,
  parameter logic [31:0] TRIM_STEP = NO_TRIM_STEP
)
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic [TRIM_W-1:0] trim,
  output logic wave,
  output logic ready
);
  logic [31:0] phase_r;
  logic [31:0] trimExt;
  logic [31:0] phaseStep;
  logic [STARTUP_CNT_W-1:0] startCnt_r;

  assign trimExt = {{(32-TRIM_W){trim[TRIM_W-1]}}, trim};
  assign phaseStep = PHASE_INC + trimExt * TRIM_STEP; // R15
  assign wave = phase_r[31];

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
      phase_r <= 32'h00000000;
    else if (!enable)
      phase_r <= 32'h00000000;
    else
      phase_r <= phase_r + phaseStep; // R01
  end

  // Shut-down oscillator needs the full start-up time again
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      startCnt_r <= '0;
      ready <= 1'b0;
    end
    else if (!enable)
    begin
      startCnt_r <= '0;
      ready <= 1'b0;
    end
    else if (startCnt_r != STARTUP_LAST)
      startCnt_r <= startCnt_r + 1'b1; // R07
    else
      ready <= 1'b1;
  end

  property p_ready_after_delay;
    @(posedge clk_sys) disable iff (!reset_n)
    $rose(ready) |-> startCnt_r == STARTUP_LAST && $past(enable) && enable;
  endproperty
  a_ready_after_delay: assert property (p_ready_after_delay) // R07
    else $error("oscillator ready without start-up delay");
endmodule
`default_nettype wire

// ---- pkg/osc_clock_pkg.sv ----
// Constants, types and helpers shared by the internal oscillator clock select
package osc_clock_pkg;

  localparam int SYS_CLK_MHZ = 100;
  localparam int CLK_PERIOD_NS = 10;
  localparam int STARTUP_DELAY_US = 10;
  localparam int STARTUP_CYC = (STARTUP_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STARTUP_CNT_W = 10;
  localparam logic [STARTUP_CNT_W-1:0] STARTUP_LAST = STARTUP_CNT_W'(STARTUP_CYC - 1);

  // Phase increments per clk_sys cycle: f * 2^32 / 100 MHz
  localparam logic [31:0] HF_PHASE_INC = 32'h147AE148;
  localparam logic [31:0] LF_PHASE_INC = 32'h00145A70;
  localparam logic [31:0] HF_TRIM_STEP = HF_PHASE_INC >> 7;
  localparam logic [31:0] NO_TRIM_STEP = 32'h00000000;

  localparam int TRIM_W = 5;
  localparam logic [TRIM_W-1:0] TRIM_RESET = 5'h00;
  localparam logic signed [TRIM_W:0] TRIM_MAX = 6'sh0F;
  localparam logic signed [TRIM_W:0] TRIM_MIN = -6'sh10;

  localparam int FREQ_W = 3;
  localparam logic [FREQ_W-1:0] FREQ_31K = 3'h0;
  localparam logic [FREQ_W-1:0] FREQ_4M = 3'h6;
  localparam logic [FREQ_W-1:0] FREQ_RESET = FREQ_4M;
  localparam int TAP_W = 8;
  localparam int PSC_W = 6;
  localparam int DIVIDED_CLOCK_OUT_CNT_W = 2;

  localparam int CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_INTOSC_DIVIDED_CLOCK_OUT = 3'h5;
  localparam logic [CFG_W-1:0] CFG_INTOSC_IO = 3'h4;
  localparam logic [CFG_W-1:0] CFG_RESET = 3'h0;

  localparam int PROG_ADDR_W = 14;
  localparam logic [PROG_ADDR_W-1:0] FACTORY_TRIM_ADDR = 14'h2008;
  localparam logic [PROG_ADDR_W-1:0] CFG_SPACE_LO = 14'h2000;
  localparam logic [PROG_ADDR_W-1:0] FACTORY_TRIM_RESET = 14'h0000;

  typedef enum logic [3:0]
  {
    ST_IDLE = 4'h1,
    ST_STARTUP = 4'h2,
    ST_WAIT_FALL = 4'h4,
    ST_WAIT_RISE = 4'h8
  } switch_state_t;

  function automatic logic usesHighOsc(input logic internalSel, input logic [FREQ_W-1:0] code);
    return internalSel && (code != FREQ_31K);
  endfunction

  function automatic logic usesLowOsc(input logic internalSel, input logic [FREQ_W-1:0] code);
    return internalSel && (code == FREQ_31K);
  endfunction

  function automatic logic tapSelect(input logic [TAP_W-1:0] taps, input logic [FREQ_W-1:0] code);
    return taps[code];
  endfunction

endpackage

// ---- test/divided_clock_out_receiver.sv ----
// Far-side circuit that times the divided clock arriving on pin B
`timescale 1ns/1ps
`default_nettype none
module divided_clock_out_receiver
(
  input wire logic clk_sys,
  input wire logic pinLevel,
  output logic [15:0] period
);
  logic prevLevel;
  logic [15:0] count;
  // Only listens; the pin is never driven from this side
  always_ff @(posedge clk_sys)
  begin
    prevLevel <= pinLevel;
    count <= (pinLevel && !prevLevel) ? 16'h0001 : count + 16'h0001;
    if (pinLevel && !prevLevel)
    begin
      period <= count;
    end
  end
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the internal oscillator clock select
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
  begin \
    nChecks++; \
    if ((a) !== (e)) \
    begin \
      errorCnt++; \
      $display("wrong value at %0t: %h expected %h", $time, a, e); \
    end \
  end
module testbench
  import osc_clock_pkg::*;
;
  logic clk_sys = 1'b0, reset_n = 1'b0, extClkIn = 1'b0;
  logic freqSelectWr = 1'b0, clockSourceSelect = 1'b1, twoSpeedStartupEn = 1'b0;
  logic powerupTimerEn = 1'b0, watchdogTimerEn = 1'b0, failsafeMonitorEn = 1'b0;
  logic oscTrimWr = 1'b0, progMode = 1'b0, progWr = 1'b0, bulkErase = 1'b0;
  logic gpioAOut = 1'b1, gpioAOe = 1'b1, gpioBOut = 1'b0, gpioBOe = 1'b0;
  logic [FREQ_W-1:0] freqSelectIn = FREQ_RESET, freqSelect;
  logic [TRIM_W-1:0] oscTrimIn = TRIM_RESET, oscTrim;
  logic [CFG_W-1:0] oscConfigSelect = CFG_INTOSC_DIVIDED_CLOCK_OUT;
  logic [PROG_ADDR_W-1:0] progAddr = 14'h0000, progWrData = 14'h0000;
  logic [PROG_ADDR_W-1:0] factoryTrimWord, progRdData;
  logic highOscStable, lowOscStable, highOscRun, lowOscRun, switchBusy, sysClock;
  logic lowFreqClock, dividedClockOut, oscPinAOut, oscPinAOe, oscPinBOut, oscPinBOe;
  logic padB;
  logic [15:0] rxPeriod;
  int errorCnt = 0, nChecks = 0, used;
  int sysRises = 0, lfRises = 0;

  always #5 clk_sys = ~clk_sys;
  always #20 extClkIn = ~extClkIn;
  always @(posedge sysClock) sysRises++;
  always @(posedge lowFreqClock) lfRises++;
  // Board pull-up keeps a released pin high
  assign padB = oscPinBOe ? oscPinBOut : 1'b1;

  internal_osc_clock_select internal_osc_clock_select_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .freqSelectWr(freqSelectWr),
    .freqSelectIn(freqSelectIn), .clockSourceSelect(clockSourceSelect),
    .twoSpeedStartupEn(twoSpeedStartupEn), .powerupTimerEn(powerupTimerEn),
    .watchdogTimerEn(watchdogTimerEn), .failsafeMonitorEn(failsafeMonitorEn),
    .oscTrimWr(oscTrimWr), .oscTrimIn(oscTrimIn), .oscConfigSelect(oscConfigSelect),
    .extClkIn(extClkIn), .gpioAOut(gpioAOut), .gpioAOe(gpioAOe), .gpioBOut(gpioBOut),
    .gpioBOe(gpioBOe), .progMode(progMode), .progWr(progWr), .progAddr(progAddr),
    .progWrData(progWrData), .bulkErase(bulkErase), .freqSelect(freqSelect),
    .oscTrim(oscTrim), .highOscStable(highOscStable), .lowOscStable(lowOscStable),
    .highOscRun(highOscRun), .lowOscRun(lowOscRun), .switchBusy(switchBusy),
    .sysClock(sysClock), .lowFreqClock(lowFreqClock), .dividedClockOut(dividedClockOut),
    .oscPinAOut(oscPinAOut), .oscPinAOe(oscPinAOe), .oscPinBOut(oscPinBOut),
    .oscPinBOe(oscPinBOe), .factoryTrimWord(factoryTrimWord), .progRdData(progRdData)
  );
  divided_clock_out_receiver divided_clock_out_receiver_i (.clk_sys(clk_sys), .pinLevel(padB), .period(rxPeriod));

  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  task automatic endSim();
    $display("checks %0d mismatches %0d", nChecks, errorCnt);
    if (errorCnt == 0 && nChecks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic doReset(input logic [CFG_W-1:0] cfg);
    reset_n = 1'b0;
    oscConfigSelect = cfg;
    tick(2);
    reset_n = 1'b1;
    tick(2);
  endtask

  task automatic writeFreq(input logic [FREQ_W-1:0] code);
    freqSelectIn = code;
    freqSelectWr = 1'b1;
    tick(1);
    freqSelectWr = 1'b0;
    tick(2);
  endtask

  // Bounded wait; running out ends the run as a mismatch
  task automatic waitIdle(input int lim);
    used = 0;
    while (switchBusy !== 1'b0)
    begin
      if (used == lim)
      begin
        errorCnt++;
        endSim();
      end
      tick(1);
      used++;
    end
  endtask

  task automatic progWrite(input logic [PROG_ADDR_W-1:0] a, input logic [PROG_ADDR_W-1:0] d);
    progAddr = a;
    progWrData = d;
    progWr = 1'b1;
    tick(1);
    progWr = 1'b0;
    tick(1);
  endtask

  initial
  begin
    #1000000;
    errorCnt++;
    endSim();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    doReset(CFG_INTOSC_DIVIDED_CLOCK_OUT);
    `CHK(freqSelect, 3'h6)
    `CHK(highOscRun, 1'b1)
    `CHK(lowOscRun, 1'b0)
    `CHK(oscPinBOe, 1'b1)
    `CHK({oscPinAOe, oscPinAOut}, 2'h3)
    for (used = 0; used < 1100 && highOscStable !== 1'b1; used++) tick(1);
    `CHK(highOscStable, 1'b1)
    tick(400);
    `CHK(rxPeriod >= 16'h0063 && rxPeriod <= 16'h0065, 1'b1)
    $display("test reset and clock out done");
    for (int k = 0; k < 3; k++)
    begin
      {powerupTimerEn, watchdogTimerEn, failsafeMonitorEn} = 3'h1 << k;
      tick(1);
      `CHK(lowOscRun, 1'b1)
      {powerupTimerEn, watchdogTimerEn, failsafeMonitorEn} = 3'h0;
      tick(1);
      `CHK(lowOscRun, 1'b0)
    end
    writeFreq(3'h7);
    waitIdle(9000);
    `CHK(used < 100, 1'b1)
    `CHK(highOscStable, 1'b1)
    used = sysRises;
    tick(300);
    `CHK(sysRises - used >= 23 && sysRises - used <= 25, 1'b1)
    `CHK(rxPeriod >= 16'h0031 && rxPeriod <= 16'h0033, 1'b1)
    writeFreq(3'h5);
    waitIdle(9000);
    `CHK(used < 100, 1'b1)
    tick(500);
    `CHK(rxPeriod >= 16'h00C7 && rxPeriod <= 16'h00C9, 1'b1)
    writeFreq(3'h7);
    waitIdle(9000);
    oscTrimIn = 5'h0F;
    oscTrimWr = 1'b1;
    tick(1);
    oscTrimWr = 1'b0;
    tick(300);
    `CHK(oscTrim, 5'h0F)
    `CHK(rxPeriod <= 16'h002F, 1'b1)
    $display("test fast switch and trim done");
    writeFreq(FREQ_31K);
    `CHK(lowOscRun, 1'b1)
    tick(900);
    `CHK(switchBusy, 1'b1)
    waitIdle(9000);
    `CHK(lowOscStable, 1'b1)
    `CHK(lfRises != 0, 1'b1)
    `CHK(highOscRun, 1'b0)
    twoSpeedStartupEn = 1'b1;
    clockSourceSelect = 1'b0;
    tick(3);
    `CHK(highOscRun, 1'b0)
    waitIdle(9000);
    `CHK(lowOscRun, 1'b1)
    `CHK(highOscStable, 1'b0)
    writeFreq(3'h7);
    `CHK(highOscRun, 1'b1)
    waitIdle(9000);
    twoSpeedStartupEn = 1'b0;
    tick(1);
    `CHK({highOscRun, lowOscRun}, 2'h0)
    $display("test slow switch and sources done");
    progMode = 1'b1;
    progWrite(FACTORY_TRIM_ADDR, 14'h001F);
    `CHK(factoryTrimWord, 14'h001F)
    bulkErase = 1'b1;
    progWrite(FACTORY_TRIM_ADDR, 14'h0002);
    bulkErase = 1'b0;
    progWrite(14'h2009, 14'h0003);
    `CHK(progRdData, 14'h0000)
    progMode = 1'b0;
    progWrite(FACTORY_TRIM_ADDR, 14'h0004);
    `CHK(factoryTrimWord, 14'h001F)
    progMode = 1'b1;
    progAddr = FACTORY_TRIM_ADDR;
    tick(2);
    `CHK(progRdData, 14'h001F)
    $display("test factory word done");
    doReset(CFG_INTOSC_IO);
    `CHK({oscPinAOe, oscPinBOe}, 2'h2)
    gpioBOe = 1'b1;
    tick(1);
    `CHK({oscPinBOe, oscPinBOut}, 2'h2)
    $display("test io mode done");
    endSim();
  end
endmodule
`default_nettype wire
